// File: include/sleep_clk_pkg.sv
package sleep_clk_pkg;

  // I/O map: dedicated I/O offsets, data space is offset plus DS_OFFSET
  localparam logic [5:0] IO_TRIM = 6'h31;
  localparam logic [5:0] IO_PCR = 6'h35;
  localparam logic [7:0] DS_OFFSET = 8'h20;

  // Power control register layout
  localparam int PCR_GATE_BIT = 5;
  localparam int PCR_SEL_LSB = 2;
  localparam int PCR_SEL_MSB = 4;
  localparam logic [7:0] PCR_RESET = 8'h00;
  localparam logic [7:0] PCR_MASK = 8'h3c;

  // Sleep select codes
  localparam logic [2:0] SEL_IDLE = 3'h0;
  localparam logic [2:0] SEL_NOISE = 3'h1;
  localparam logic [2:0] SEL_PDOWN = 3'h2;
  localparam logic [2:0] SEL_PSAVE = 3'h3;
  localparam logic [2:0] SEL_STANDBY = 3'h6;

  // Wake timing, in oscillator clock cycles
  localparam logic [7:0] HALT_CK = 8'h04;
  localparam logic [7:0] STANDBY_WAKE_CK = 8'h06;
  localparam logic [7:0] PDOWN_WAKE_CK = 8'h06;

  // Bit positions in the clock and oscillator enable vector
  localparam int G_CORE = 0;
  localparam int G_MEM = 1;
  localparam int G_IO = 2;
  localparam int G_CONV = 3;
  localparam int G_ASY = 4;
  localparam int G_MAIN = 5;
  localparam int G_TOSC = 6;
  localparam int G_W = 7;
  localparam logic [6:0] GATES_RUN = 7'h7f;

  typedef enum logic [1:0] {run_st, sleep_st, wake_st} power_state_e;

endpackage

// File: rtl/level_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for levels arriving from pins
module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Both stages reset high: external lines idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// File: rtl/sleep_clock_gating_and_osc_trim.sv
// Summary of operation
// R1: Trim register at I/O 0x31, data 0x51.
// R2: Data-space address equals I/O offset plus 0x20.
// R3: Reset loads factory calibration byte into trim.
// R4: Trim zero slowest, rising monotonically to 0xff.
// R5: Trim endpoints give rough frequency ranges only.
// R6: Software keeps trim low during memory writes.
// R7: Sleep only when gate bit set at instruction.
// R8: Idle stops core and memory clocks, and async clocks when the async bit is clear.
// R9: Noise mode also stops the I/O clock.
// R10: Wake holds core four cycles beyond start-up.
// R11: Register file and SRAM kept across sleep.
// R12: Reset during sleep restarts from reset vector.
// R13: Idle or noise entry starts enabled conversion.
// R14: Noise mode wakes only from listed sources.
// R15: Deep modes ignore edge-triggered external interrupts.
// R16: Async timer runs, and wakes outside idle, only when enabled; run and wake keep async clock and timer oscillator on regardless.
// R17: Standby needs crystal; main source stays enabled.
// R18: Power-down and standby wake on address or level.
// R19: Code 010 power-down, wake after start-up delay.
// R20: Code 011 power-save keeps async timer two.
// R21: Code 110 standby, wakes in six cycles.
// R22: Power control register at 0x35, resets zero.
// R23: Reserved select codes make sleep a no-op.
`timescale 1ns/10ps
`default_nettype none

module sleep_clock_gating_and_osc_trim
  import sleep_clk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic sleep_exec,
  input wire logic [7:0] factory_trim,
  input wire logic crystal_selected,
  input wire logic async_timer_clock_bit,
  input wire logic converter_enabled,
  input wire logic [1:0] ext_irq_pins,
  input wire logic [1:0] ext_irq_level,
  input wire logic [1:0] ext_irq_enable,
  input wire logic conv_done_irq,
  input wire logic addr_match_irq,
  input wire logic timer_two_irq,
  input wire logic nvm_ready_irq,
  input wire logic other_io_irq,
  output logic core_clock_en,
  output logic memory_clock_en,
  output logic io_clock_en,
  output logic converter_clock_en,
  output logic async_clock_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic core_hold,
  output logic conv_start,
  output logic sleep_active,
  output logic [7:0] oscillator_trim
);

  // Stored control state
  logic [7:0] power_control_register; // Gate bit and select field
  power_state_e state; // Run, asleep, or waking
  logic [2:0] sleep_mode; // Mode latched at sleep entry
  logic [7:0] wake_cnt; // Remaining hold cycles while waking
  logic [6:0] gates; // Registered clock and oscillator enables
  logic [1:0] ext_s; // Synchronised external interrupt lines
  logic [1:0] ext_d; // Previous synchronised level, for edges

  // Access decode
  logic [7:0] mem_io; // Data-space address moved to I/O offset
  logic mem_in_io; // Data access lands in the I/O window
  logic acc_wr; // Write to an I/O offset by either path
  logic acc_rd; // Read of an I/O offset by either path
  logic [5:0] acc_off; // Offset addressed by the access

  // Sleep and wake decode
  logic sleep_gate_bit;
  logic [2:0] sleep_select_field;
  logic mode_ok; // Select code names a mode this part can enter
  logic [1:0] ext_lvl; // Enabled level-mode external requests
  logic [1:0] ext_edge; // Enabled edge-mode external requests
  logic wake_now; // Wake condition for the current sleep mode

  // Clock enables for a mode; timer oscillator and async clock follow the
  // async bit in idle, noise and power-save, so an unused crystal does not burn power
  function automatic logic [6:0] mode_gates(input logic [2:0] m, input logic as2);
    logic [6:0] g;
    g = '0;
    g[G_ASY] = as2; // R16
    g[G_TOSC] = as2; // R16
    unique case (m)
      SEL_IDLE: begin
        g[G_IO] = 1'b1; // R8
        g[G_CONV] = 1'b1; // R8
        g[G_MAIN] = 1'b1; // R8
      end
      SEL_NOISE: begin
        g[G_CONV] = 1'b1; // R9
        g[G_MAIN] = 1'b1; // R9
      end
      SEL_STANDBY: begin
        g[G_MAIN] = 1'b1; // R17
        g[G_ASY] = 1'b0; // R18
        g[G_TOSC] = 1'b0; // R18
      end
      SEL_PSAVE: begin
        g = g; // R20
      end
      default: begin
        g[G_ASY] = 1'b0; // R19
        g[G_TOSC] = 1'b0; // R19
      end
    endcase
    return g;
  endfunction

  // Cycles the core is held after a wake condition
  function automatic logic [7:0] wake_len(input logic [2:0] m);
    logic [7:0] n;
    n = HALT_CK; // R10
    if (m == SEL_PDOWN || m == SEL_PSAVE) begin
      n = PDOWN_WAKE_CK + HALT_CK; // R19
    end else if (m == SEL_STANDBY) begin
      n = STANDBY_WAKE_CK + HALT_CK; // R21
    end
    return n;
  endfunction

  // Pins come from outside the clock domain
  level_sync #(.WIDTH(2)) u_ext_sync (
    .clk(clk),
    .rst(rst),
    .async_in(ext_irq_pins),
    .sync_out(ext_s)
  );

  // Map both access paths onto one I/O offset
  always_comb begin
    mem_io = mem_addr - DS_OFFSET; // R2
    mem_in_io = (mem_io[7:6] == 2'b00); // R2
    acc_wr = io_wr | (mem_wr & mem_in_io);
    acc_rd = io_rd | (mem_rd & mem_in_io);
    // The core issues one access at a time; the I/O path wins regardless
    acc_off = io_wr | io_rd ? io_addr : mem_io[5:0];
  end

  // Select decode; standby code without a crystal counts as reserved
  always_comb begin
    sleep_gate_bit = power_control_register[PCR_GATE_BIT];
    sleep_select_field = power_control_register[PCR_SEL_MSB:PCR_SEL_LSB];
    unique case (sleep_select_field)
      SEL_IDLE, SEL_NOISE, SEL_PDOWN, SEL_PSAVE: mode_ok = 1'b1;
      SEL_STANDBY: mode_ok = crystal_selected; // R17
      default: mode_ok = 1'b0; // R23
    endcase
  end

  // Wake sources allowed in the mode that was entered
  always_comb begin
    ext_lvl = ext_irq_enable & ext_irq_level & ~ext_s;
    ext_edge = ext_irq_enable & ~ext_irq_level & (ext_s ^ ext_d);
    unique case (sleep_mode)
      SEL_IDLE: begin
        wake_now = (|ext_lvl) | (|ext_edge) | conv_done_irq | addr_match_irq |
                   timer_two_irq | nvm_ready_irq | other_io_irq;
      end
      SEL_NOISE: begin
        // Edge requests and general I/O interrupts cannot wake here
        wake_now = conv_done_irq | addr_match_irq | nvm_ready_irq | (|ext_lvl) | // R14 R15
                   (timer_two_irq & async_timer_clock_bit); // R16
      end
      SEL_PSAVE: begin
        wake_now = addr_match_irq | (|ext_lvl) | // R15 R20
                   (timer_two_irq & async_timer_clock_bit); // R16
      end
      default: begin
        wake_now = addr_match_irq | (|ext_lvl); // R18
      end
    endcase
  end

  // Edge history for edge-mode external interrupts
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_d <= '1;
    end else begin
      ext_d <= ext_s;
    end
  end

  // Trim register; the reset value is the part's own calibration byte,
  // taken while reset is asserted so the oscillator is trimmed at release
  always_ff @(posedge clk) begin
    if (rst) begin
      oscillator_trim <= factory_trim; // R3
    end else if (acc_wr && acc_off == IO_TRIM) begin
      // Value goes straight to the oscillator; monotonic code to frequency
      oscillator_trim <= wdata; // R1 R4 R5
    end
  end

  // Power control register; unused bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      power_control_register <= PCR_RESET; // R22
    end else if (acc_wr && acc_off == IO_PCR) begin
      power_control_register <= wdata & PCR_MASK; // R22
    end
  end

  // Registered read data; other offsets answer zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (acc_rd) begin
      if (acc_off == IO_TRIM) begin
        rdata <= oscillator_trim; // R1
      end else if (acc_off == IO_PCR) begin
        rdata <= power_control_register; // R22
      end else begin
        rdata <= '0;
      end
    end
  end

  // Sleep sequencer. Reset returns straight to run with clocks on and the
  // core released, so it restarts at its reset vector. Only clocks are
  // gated: no storage is cleared on entry or exit.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= run_st; // R12
      sleep_mode <= SEL_IDLE;
      wake_cnt <= '0;
      gates <= GATES_RUN; // R12
      core_hold <= 1'b0; // R12
      sleep_active <= 1'b0;
    end else begin
      unique case (state)
        run_st: begin
          if (sleep_exec && sleep_gate_bit && mode_ok) begin // R7 R23
            state <= sleep_st;
            sleep_mode <= sleep_select_field; // R7
            gates <= mode_gates(sleep_select_field, async_timer_clock_bit); // R8 R9
            core_hold <= 1'b1; // R11
            sleep_active <= 1'b1;
          end
        end
        sleep_st: begin
          gates <= mode_gates(sleep_mode, async_timer_clock_bit); // R16
          if (wake_now) begin
            state <= wake_st;
            wake_cnt <= wake_len(sleep_mode); // R10
            gates <= GATES_RUN;
            sleep_active <= 1'b0;
          end
        end
        wake_st: begin
          wake_cnt <= wake_cnt - 8'h01;
          if (wake_cnt == 8'h01) begin
            // Core resumes and takes the pending interrupt
            state <= run_st; // R10
            core_hold <= 1'b0; // R10
          end
        end
      endcase
    end
  end

  // Conversion start pulse on entry to the quiet modes
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= (state == run_st) && sleep_exec && sleep_gate_bit && mode_ok &&
                    converter_enabled && // R13
                    (sleep_select_field == SEL_IDLE || sleep_select_field == SEL_NOISE);
    end
  end

  // Gate vector out to the clock tree
  always_comb begin
    core_clock_en = gates[G_CORE];
    memory_clock_en = gates[G_MEM];
    io_clock_en = gates[G_IO];
    converter_clock_en = gates[G_CONV];
    async_clock_en = gates[G_ASY];
    main_osc_en = gates[G_MAIN];
    timer_osc_en = gates[G_TOSC];
  end

  // Checks

  a_trim_reset_load: // R3
  assert property (@(posedge clk) rst |=> oscillator_trim == $past(factory_trim))
    else $error("trim not loaded from calibration byte");

  a_trim_ds_write: // R1
  assert property (@(posedge clk) disable iff (rst)
    (mem_wr && !io_wr && !io_rd && mem_addr == 8'h51) |=> oscillator_trim == $past(wdata))
    else $error("data-space trim write lost");

  a_pcr_reset_zero: // R22
  assert property (@(posedge clk) rst |=> power_control_register == 8'h00)
    else $error("power control not zero after reset");

  a_gate_bit_needed: // R7
  assert property (@(posedge clk) disable iff (rst)
    (state == run_st && sleep_exec && !sleep_gate_bit) |=> state == run_st && core_clock_en)
    else $error("slept without gate bit");

  a_reserved_is_nop: // R23
  assert property (@(posedge clk) disable iff (rst)
    (state == run_st && sleep_select_field inside {3'h4, 3'h5, 3'h7})
    |=> state == run_st && gates == GATES_RUN)
    else $error("reserved code gated clocks");

  a_idle_gating: // R8
  assert property (@(posedge clk) disable iff (rst)
    (state == sleep_st && sleep_mode == SEL_IDLE)
    |-> !core_clock_en && !memory_clock_en && io_clock_en && converter_clock_en)
    else $error("idle gating wrong");

  a_noise_gating: // R9
  assert property (@(posedge clk) disable iff (rst)
    (state == sleep_st && sleep_mode == SEL_NOISE)
    |-> !io_clock_en && !core_clock_en && converter_clock_en && main_osc_en)
    else $error("noise mode gating wrong");

  a_idle_wake_hold: // R10
  assert property (@(posedge clk) disable iff (rst)
    (state == sleep_st && wake_now && sleep_mode == SEL_IDLE)
    |=> core_hold [*4] ##1 !core_hold)
    else $error("idle wake hold not four cycles");

  a_standby_wake_hold: // R21
  assert property (@(posedge clk) disable iff (rst)
    (state == sleep_st && wake_now && sleep_mode == SEL_STANDBY)
    |=> core_hold [*8] ##1 core_hold ##1 core_hold ##1 !core_hold)
    else $error("standby wake hold wrong");

  a_conv_autostart: // R13
  assert property (@(posedge clk) disable iff (rst)
    (state == run_st && sleep_exec && sleep_gate_bit && converter_enabled &&
     sleep_select_field == SEL_NOISE) |=> conv_start && state == sleep_st)
    else $error("conversion not started on entry");

  a_pdown_edge_ignored: // R15
  assert property (@(posedge clk) disable iff (rst)
    (state == sleep_st && sleep_mode == SEL_PDOWN && !addr_match_irq && ext_lvl == 2'b00)
    |=> state == sleep_st)
    else $error("power-down woke from non-level source");

endmodule

`default_nettype wire

// File: verif/core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Processor core stand-in: register accesses and the sleep instruction
module core_model
  import sleep_clk_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] mem_addr,
  output logic mem_wr,
  output logic mem_rd,
  output logic [7:0] wdata,
  output logic sleep_exec
);
  // Quiet bus at time zero so no strobe starts unknown
  initial begin
    io_addr = 6'h00;
    mem_addr = 8'h00;
    wdata = 8'h00;
    {io_wr, io_rd, mem_wr, mem_rd, sleep_exec} = 5'h00;
  end

  // Dedicated I/O write; address and data flip once the strobe is gone
  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    wdata <= ~d;
  endtask

  // Dedicated I/O read; data taken a cycle after the strobe edge
  task automatic io_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1;
    d = rdata;
  endtask

  // Load/store path: same register at offset plus the window base
  task automatic mem_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_addr <= {2'b00, a} + DS_OFFSET;
    wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_addr <= 8'h00;
    wdata <= ~d;
  endtask

  task automatic mem_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    mem_addr <= {2'b00, a} + DS_OFFSET;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    mem_addr <= 8'h00;
    #1;
    d = rdata;
  endtask

  // No memory write is ever in flight here, so any trim value is safe
  task automatic sleep_op();
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
  endtask
endmodule

`default_nettype wire

// File: verif/test_sleep_clock_gating_and_osc_trim.sv
`timescale 1ns/10ps
`default_nettype none

module test_sleep_clock_gating_and_osc_trim
  import sleep_clk_pkg::*;
;
  logic clk, rst, crystal_selected, async_timer_clock_bit, converter_enabled;
  logic [7:0] factory_trim;
  logic [1:0] ext_irq_pins, ext_irq_level, ext_irq_enable;
  logic conv_done_irq, addr_match_irq, timer_two_irq, nvm_ready_irq, other_io_irq;
  wire logic [5:0] io_addr;
  wire logic io_wr, io_rd, mem_wr, mem_rd, sleep_exec;
  wire logic [7:0] mem_addr, wdata, rdata, oscillator_trim;
  wire logic core_clock_en, memory_clock_en, io_clock_en, converter_clock_en;
  wire logic async_clock_en, main_osc_en, timer_osc_en, core_hold, conv_start, sleep_active;
  // Enables packed in the package's bit order
  wire logic [6:0] gates = {timer_osc_en, main_osc_en, async_clock_en, converter_clock_en,
    io_clock_en, memory_clock_en, core_clock_en};
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] d;

  sleep_clock_gating_and_osc_trim DUT (.clk, .rst, .io_addr, .io_wr, .io_rd, .mem_addr,
    .mem_wr, .mem_rd, .wdata, .rdata, .sleep_exec, .factory_trim, .crystal_selected,
    .async_timer_clock_bit, .converter_enabled, .ext_irq_pins, .ext_irq_level,
    .ext_irq_enable, .conv_done_irq, .addr_match_irq, .timer_two_irq, .nvm_ready_irq,
    .other_io_irq, .core_clock_en, .memory_clock_en, .io_clock_en, .converter_clock_en,
    .async_clock_en, .main_osc_en, .timer_osc_en, .core_hold, .conv_start, .sleep_active,
    .oscillator_trim);
  core_model CORE (.clk, .rdata, .io_addr, .io_wr, .io_rd, .mem_addr, .mem_wr, .mem_rd,
    .wdata, .sleep_exec);

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Program the power control register, then execute sleep
  task automatic go_sleep(input logic [2:0] code, input logic gate);
    CORE.io_write(IO_PCR, {2'b00, gate, code, 2'b00});
    CORE.sleep_op();
  endtask

  // Bounded wait for wake, then measure how long the core stays held
  task automatic wake_check(input logic [7:0] hold);
    int n;
    n = 0;
    while (sleep_active === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      $display("BAD %0t no wake", $time);
      give_verdict();
    end
    chk({1'b0, gates}, {1'b0, GATES_RUN}, "gates after wake");
    n = 0;
    while (core_hold === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), hold, "hold length");
    @(posedge clk);
    {conv_done_irq, addr_match_irq, timer_two_irq, nvm_ready_irq, other_io_irq} <= 5'h00;
    ext_irq_pins <= 2'b11;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    #1;
    chk(oscillator_trim, 8'ha5, "trim at reset");
    chk({1'b0, gates}, {1'b0, GATES_RUN}, "gates at reset");
    CORE.io_read(IO_PCR, d);
    chk(d, PCR_RESET, "pcr reset");
    $display("test reset done");
  endtask

  task automatic t_regs();
    CORE.io_write(IO_TRIM, 8'hff);
    CORE.mem_read(IO_TRIM, d);
    chk(d, 8'hff, "trim via data space");
    chk(oscillator_trim, 8'hff, "trim top");
    CORE.mem_write(IO_TRIM, 8'h00);
    CORE.io_read(IO_TRIM, d);
    chk(d, 8'h00, "trim via io");
    CORE.io_write(IO_TRIM, 8'h7f);
    CORE.mem_write(IO_PCR, 8'hff);
    CORE.io_read(IO_PCR, d);
    chk(d, PCR_MASK, "pcr bits");
    chk(oscillator_trim, 8'h7f, "trim mid");
    CORE.io_read(6'h10, d);
    chk(d, 8'h00, "unmapped read");
    $display("test regs done");
  endtask

  task automatic t_modes();
    logic [2:0] codes [5] = '{SEL_IDLE, SEL_NOISE, SEL_PDOWN, SEL_PSAVE, SEL_STANDBY};
    logic [6:0] expg [5] = '{7'h7c, 7'h78, 7'h00, 7'h50, 7'h20};
    logic [7:0] holds [5] = '{HALT_CK, HALT_CK, HALT_CK + PDOWN_WAKE_CK,
      HALT_CK + PDOWN_WAKE_CK, STANDBY_WAKE_CK + HALT_CK};
    for (int i = 0; i < 5; i++) begin
      go_sleep(codes[i], 1'b1);
      chk({1'b0, gates}, {1'b0, expg[i]}, "mode gates");
      chk({7'h00, conv_start}, {7'h00, (i < 2)}, "conv start");
      chk({6'h00, sleep_active, core_hold}, 8'h03, "asleep");
      @(posedge clk);
      addr_match_irq <= 1'b1;
      wake_check(holds[i]);
      // Step off the edge so the trim is read settled
      #1;
      chk(oscillator_trim, 8'h7f, "trim kept");
    end
    $display("test modes done");
  endtask

  task automatic t_refused();
    logic [3:0] cfg [5] = '{4'h0, 4'hc, 4'hd, 4'hf, 4'he};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      crystal_selected <= (i < 4);
      go_sleep(cfg[i][2:0], cfg[i][3]);
      chk({7'h00, sleep_active}, 8'h00, "no sleep");
      chk({1'b0, gates}, {1'b0, GATES_RUN}, "gates run");
    end
    // Restore the crystal on a rising edge, like every other input
    @(posedge clk);
    crystal_selected <= 1'b1;
    $display("test refused done");
  endtask

  task automatic t_sources();
    go_sleep(SEL_NOISE, 1'b1);
    @(posedge clk);
    other_io_irq <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, sleep_active}, 8'h01, "noise ignores other io");
    @(posedge clk);
    nvm_ready_irq <= 1'b1;
    wake_check(HALT_CK);
    go_sleep(SEL_PDOWN, 1'b1);
    @(posedge clk);
    ext_irq_pins <= 2'b10;
    timer_two_irq <= 1'b1;
    conv_done_irq <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({7'h00, sleep_active}, 8'h01, "edge and timer ignored");
    @(posedge clk);
    ext_irq_level <= 2'b01;
    wake_check(HALT_CK + PDOWN_WAKE_CK);
    ext_irq_level <= 2'b00;
    async_timer_clock_bit <= 1'b0;
    go_sleep(SEL_PSAVE, 1'b1);
    chk({1'b0, gates}, 8'h00, "psave no async");
    @(posedge clk);
    timer_two_irq <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, sleep_active}, 8'h01, "timer two gated");
    @(posedge clk);
    async_timer_clock_bit <= 1'b1;
    wake_check(HALT_CK + PDOWN_WAKE_CK);
    // Idle with the converter off: no start pulse, and an edge-mode line wakes
    converter_enabled <= 1'b0;
    go_sleep(SEL_IDLE, 1'b1);
    chk({7'h00, conv_start}, 8'h00, "no start when disabled");
    chk({1'b0, gates}, 8'h7c, "idle gates");
    @(posedge clk);
    ext_irq_pins <= 2'b01;
    wake_check(HALT_CK);
    $display("test sources done");
  endtask

  task automatic t_reset_sleep();
    go_sleep(SEL_PDOWN, 1'b1);
    @(posedge clk);
    factory_trim <= 8'h3c;
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h00, sleep_active, core_hold}, 8'h00, "reset wakes");
    chk({1'b0, gates}, {1'b0, GATES_RUN}, "reset gates");
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(oscillator_trim, 8'h3c, "trim reloaded");
    CORE.io_read(IO_PCR, d);
    chk(d, PCR_RESET, "pcr cleared");
    $display("test reset_sleep done");
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    factory_trim = 8'ha5;
    {crystal_selected, async_timer_clock_bit, converter_enabled} = 3'h7;
    ext_irq_pins = 2'b11;
    ext_irq_level = 2'b00;
    ext_irq_enable = 2'b11;
    {conv_done_irq, addr_match_irq, timer_two_irq, nvm_ready_irq, other_io_irq} = 5'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_modes();
    t_refused();
    t_sources();
    t_reset_sleep();
    give_verdict();
  end
endmodule

`default_nettype wire
